// [logic/ium_top.sv]
module ium_top
  import ium_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire ium_msr_req_t MSR_REQ,
  input wire ium_mmio_req_t MMIO_REQ,
  input wire logic [31:0] UNIT_ID,
  input wire logic EXT_CAPABLE,
  input wire logic IS_BSP,
  output logic MSR_ACK,
  output logic [31:0] MSR_RD_LO,
  output logic [31:0] MSR_RD_HI,
  output logic GP_FAULT,
  output logic MSR_MISS,
  output logic MMIO_ACK,
  output logic [31:0] MMIO_RD_DATA,
  output logic FEATURE_CAP,
  output ium_mode_t MODE,
  output logic [35:0] MMIO_BASE
);

  // ----------------------------------------------------------------
  // Mode state and base register
  // ----------------------------------------------------------------
  logic en_q;
  logic extended_mode_bit_q;
  logic bsp_q;
  logic bsp_taken_q;
  logic [23:0] base_q;
  logic [31:0] dfr_q;
  logic [63:0] icr_q;
  logic [31:0] self_q;

  ium_mode_t mode_w;
  always_comb begin
    case ({en_q, extended_mode_bit_q})
      2'b00: mode_w = IUM_DISABLED;
      2'b01: mode_w = IUM_INVALID;
      2'b10: mode_w = IUM_LEGACY;
      default: mode_w = IUM_EXTENDED;
    endcase
  end

  logic ext_on;
  logic leg_on;
  assign ext_on = (mode_w == IUM_EXTENDED);
  assign leg_on = (mode_w == IUM_LEGACY);

  // ----------------------------------------------------------------
  // Model-specific access decode
  // ----------------------------------------------------------------
  logic acc;
  logic is_base;
  logic in_range;
  logic [9:0] xofs;
  assign acc = MSR_REQ.rd | MSR_REQ.wr;
  assign is_base = (MSR_REQ.index == IUM_BASE_MSR_ADDR);
  assign in_range = (MSR_REQ.index >= IUM_XR_LO) && (MSR_REQ.index <= IUM_XR_HI);
  assign xofs = 10'(MSR_REQ.index - IUM_XR_BASE);

  // Extended offsets of the registers this unit answers.
  localparam logic [9:0] X_ID = 10'(IUM_OFS_ID >> IUM_MMIO_SHIFT);
  localparam logic [9:0] X_VER = 10'(IUM_OFS_VER >> IUM_MMIO_SHIFT);
  localparam logic [9:0] X_ICR = 10'(IUM_OFS_ICR_LO >> IUM_MMIO_SHIFT);
  localparam logic [9:0] X_SELF = 10'(IUM_OFS_SELF >> IUM_MMIO_SHIFT);

  // Proposed base-register write and its legality.
  logic new_en;
  logic new_extended_mode_bit;
  logic base_bad;
  assign new_en = MSR_REQ.lo[IUM_BIT_EN];
  assign new_extended_mode_bit = MSR_REQ.lo[IUM_BIT_EXTENDED_MODE_BIT];
  always_comb begin
    base_bad = 1'b0;
    if (new_extended_mode_bit && !new_en) begin
      base_bad = 1'b1;
    end else if (ext_on && new_en && !new_extended_mode_bit) begin
      base_bad = 1'b1;
    end else if (new_extended_mode_bit && !EXT_CAPABLE) begin
      base_bad = 1'b1;
    end
  end

  logic wr_base_ok;
  assign wr_base_ok = MSR_REQ.wr && is_base && !base_bad;

  // Register hit in the extended window.
  logic xhit;
  logic xro;
  always_comb begin
    case (xofs)
      X_ID: xhit = 1'b1;
      X_VER: xhit = 1'b1;
      X_ICR: xhit = 1'b1;
      X_SELF: xhit = 1'b1;
      default: xhit = 1'b0;
    endcase
  end
  assign xro = (xofs == X_ID) || (xofs == X_VER);

  logic [31:0] ver_word;
  assign ver_word = {7'h00, EXT_CAPABLE, IUM_MAX_LVT, 8'h00, IUM_VERSION};

  // Fault: accesses to the window outside extended mode, bad base writes,
  // unknown window registers, writes to read-only ones, reads of the write-only self register, and reserved-half writes.
  logic fault_w;
  always_comb begin
    fault_w = 1'b0;
    if (acc && in_range) begin
      if (!ext_on || !xhit) begin
        fault_w = 1'b1;
      end else if (MSR_REQ.wr && xro) begin
        fault_w = 1'b1;
      end else if (MSR_REQ.rd && (xofs == X_SELF)) begin
        fault_w = 1'b1;
      end else if (MSR_REQ.wr && (xofs != X_ICR) && (MSR_REQ.hi != 32'h0000_0000)) begin
        fault_w = 1'b1;
      end
    end else if (MSR_REQ.wr && is_base && base_bad) begin
      fault_w = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Base register state
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      en_q <= 1'b1;
      extended_mode_bit_q <= 1'b0;
      base_q <= IUM_BASE_RST;
    end else if (wr_base_ok) begin
      // Clearing both bits from extended mode is the legal exit.
      en_q <= new_en;
      extended_mode_bit_q <= new_extended_mode_bit;
      // A zero base field would map the registers onto page zero, so it keeps the old base.
      base_q <= ({MSR_REQ.hi[3:0], MSR_REQ.lo[31:IUM_BASE_LSB]} == 24'h00_0000) ? base_q :
                {MSR_REQ.hi[3:0], MSR_REQ.lo[31:IUM_BASE_LSB]};
    end
  end

  // The processor role is a strap, caught once after reset release.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bsp_q <= 1'b0;
      bsp_taken_q <= 1'b0;
    end else if (!bsp_taken_q) begin
      bsp_q <= IS_BSP;
      bsp_taken_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Writable controller registers
  // ----------------------------------------------------------------
  logic mm_leg;
  assign mm_leg = leg_on;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      icr_q <= 64'h0000_0000_0000_0000;
    end else if (MSR_REQ.wr && in_range && ext_on && xofs == X_ICR) begin
      icr_q <= {MSR_REQ.hi, MSR_REQ.lo};
    end else if (mm_leg && MMIO_REQ.wr && MMIO_REQ.ofs == IUM_OFS_ICR_LO) begin
      icr_q[31:0] <= MMIO_REQ.data;
    end else if (mm_leg && MMIO_REQ.wr && MMIO_REQ.ofs == IUM_OFS_ICR_HI) begin
      icr_q[63:32] <= MMIO_REQ.data;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dfr_q <= IUM_DFR_RST;
    end else if (mm_leg && MMIO_REQ.wr && MMIO_REQ.ofs == IUM_OFS_DFR) begin
      dfr_q <= MMIO_REQ.data;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      self_q <= 32'h0000_0000;
    end else if (MSR_REQ.wr && in_range && ext_on && xofs == X_SELF && !fault_w) begin
      self_q <= MSR_REQ.lo;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [63:0] msr_rd_w;
  always_comb begin
    msr_rd_w = 64'h0000_0000_0000_0000;
    if (is_base) begin
      msr_rd_w = {28'h000_0000, base_q, en_q, extended_mode_bit_q, 1'b0, bsp_q, 8'h00};
    end else if (in_range && ext_on) begin
      case (xofs)
        X_ID: msr_rd_w = {32'h0000_0000, UNIT_ID};
        X_VER: msr_rd_w = {32'h0000_0000, ver_word};
        X_ICR: msr_rd_w = icr_q;
        default: msr_rd_w = 64'h0000_0000_0000_0000;
      endcase
    end
  end

  logic [31:0] mm_rd_w;
  always_comb begin
    case (MMIO_REQ.ofs)
      IUM_OFS_ID: mm_rd_w = {UNIT_ID[7:0], 24'h00_0000};
      IUM_OFS_VER: mm_rd_w = ver_word;
      IUM_OFS_DFR: mm_rd_w = dfr_q;
      IUM_OFS_ICR_LO: mm_rd_w = icr_q[31:0];
      IUM_OFS_ICR_HI: mm_rd_w = icr_q[63:32];
      default: mm_rd_w = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      MSR_ACK <= 1'b0;
      GP_FAULT <= 1'b0;
      MSR_MISS <= 1'b0;
      MSR_RD_LO <= 32'h0000_0000;
      MSR_RD_HI <= 32'h0000_0000;
    end else begin
      // A faulted access is not acknowledged, so the core sees exactly one answer.
      MSR_ACK <= acc && (is_base || in_range) && !fault_w;
      GP_FAULT <= fault_w;
      // Indices outside this unit are answered by other core logic.
      MSR_MISS <= acc && !is_base && !in_range;
      if (MSR_REQ.rd && !fault_w) begin
        MSR_RD_LO <= msr_rd_w[31:0];
        MSR_RD_HI <= msr_rd_w[63:32];
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      MMIO_ACK <= 1'b0;
      MMIO_RD_DATA <= 32'h0000_0000;
    end else begin
      // Memory accesses outside legacy mode are not claimed.
      MMIO_ACK <= mm_leg && (MMIO_REQ.rd || MMIO_REQ.wr);
      MMIO_RD_DATA <= (mm_leg && MMIO_REQ.rd) ? mm_rd_w : 32'h0000_0000;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      FEATURE_CAP <= 1'b0;
      MODE <= IUM_LEGACY;
      MMIO_BASE <= {IUM_BASE_RST, 12'h000};
    end else begin
      FEATURE_CAP <= EXT_CAPABLE;
      // The accepted base write shows its new mode in the same cycle as its acknowledge.
      MODE <= wr_base_ok ? ium_mode_t'({new_en, new_extended_mode_bit}) : mode_w;
      MMIO_BASE <= {base_q, 12'h000};
    end
  end

endmodule

// [shared/ium_pkg.sv]
package ium_pkg;

  // ----------------------------------------------------------------
  // Model-specific address map
  // ----------------------------------------------------------------
  localparam logic [31:0] IUM_BASE_MSR_ADDR = 32'h0000_001B;
  localparam logic [31:0] IUM_XR_LO = 32'h0000_0800;
  localparam logic [31:0] IUM_XR_HI = 32'h0000_0BFF;
  localparam logic [31:0] IUM_XR_BASE = 32'h0000_0800;
  localparam logic [31:0] IUM_MMIO_DEF_BASE = 32'hFEE0_0000;
  localparam int IUM_MMIO_SHIFT = 4;

  // Legacy memory offsets; extended offsets are these divided by sixteen.
  localparam logic [11:0] IUM_OFS_ID = 12'h020;
  localparam logic [11:0] IUM_OFS_VER = 12'h030;
  localparam logic [11:0] IUM_OFS_DFR = 12'h0E0;
  localparam logic [11:0] IUM_OFS_ICR_LO = 12'h300;
  localparam logic [11:0] IUM_OFS_ICR_HI = 12'h310;
  localparam logic [11:0] IUM_OFS_SELF = 12'h3F0;

  // ----------------------------------------------------------------
  // Base register fields
  // ----------------------------------------------------------------
  localparam int IUM_BIT_EXTENDED_MODE_BIT = 10;
  localparam int IUM_BIT_EN = 11;
  localparam int IUM_BIT_BSP = 8;
  localparam int IUM_BASE_LSB = 12;
  localparam int IUM_BASE_MSB = 35;
  localparam logic [23:0] IUM_BASE_RST = 24'h0F_EE00;
  localparam int IUM_CAP_BIT = 21;
  localparam int IUM_VER_EXT_BIT = 24;

  // Arbitrary neutral values.
  localparam logic [7:0] IUM_VERSION = 8'h15;
  localparam logic [7:0] IUM_MAX_LVT = 8'h05;
  localparam logic [31:0] IUM_DFR_RST = 32'hFFFF_FFFF;

  typedef enum logic [1:0] {
    IUM_DISABLED,
    IUM_INVALID,
    IUM_LEGACY,
    IUM_EXTENDED
  } ium_mode_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [31:0] index;
    logic [31:0] lo;
    logic [31:0] hi;
  } ium_msr_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] ofs;
    logic [31:0] data;
  } ium_mmio_req_t;

endpackage

// [tb/ium_props.sv]
module ium_props
  import ium_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire ium_msr_req_t MSR_REQ,
  input wire ium_mmio_req_t MMIO_REQ,
  input wire logic EXT_CAPABLE,
  input wire logic MSR_ACK,
  input wire logic [31:0] MSR_RD_HI,
  input wire logic GP_FAULT,
  input wire logic MMIO_ACK,
  input wire logic FEATURE_CAP,
  input wire ium_mode_t MODE
);
  // ----------------------------------------------------------------
  // Mode and map checks
  // ----------------------------------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic any_rq;
  logic base_wr;
  logic ext;
  assign any_rq = MSR_REQ.rd || MSR_REQ.wr;
  assign base_wr = MSR_REQ.wr && MSR_REQ.index == IUM_BASE_MSR_ADDR;
  assign ext = MODE == IUM_EXTENDED;
  base_answer_a: assert property (any_rq && MSR_REQ.index == IUM_BASE_MSR_ADDR
    |=> MSR_ACK != GP_FAULT) else $error("base register access not answered");
  enter_ext_a: assert property (base_wr && MODE == IUM_LEGACY && EXT_CAPABLE
    && MSR_REQ.lo[11:10] == 2'b11 |=> ext) else $error("extended mode not entered");
  no_legacy_back_a: assert property (base_wr && ext && MSR_REQ.lo[11:10] == 2'b10
    |=> GP_FAULT && ext) else $error("illegal return to legacy mode");
  ext_exit_a: assert property (base_wr && ext && MSR_REQ.lo[11:10] == 2'b00
    |=> !GP_FAULT && MODE == IUM_DISABLED) else $error("exit from extended mode refused");
  bad_combo_a: assert property (base_wr && MSR_REQ.lo[11:10] == 2'b01
    |=> GP_FAULT && MODE == $past(MODE)) else $error("invalid mode write accepted");
  range_gate_a: assert property (any_rq && !ext && MSR_REQ.index >= IUM_XR_LO
    && MSR_REQ.index <= IUM_XR_HI |=> GP_FAULT && !MSR_ACK) else $error("range open");
  mmio_gate_a: assert property ((MMIO_REQ.rd || MMIO_REQ.wr) && MODE != IUM_LEGACY
    |=> !MMIO_ACK) else $error("memory access answered outside legacy mode");
  cap_flag_a: assert property ($past(RST_N) |-> FEATURE_CAP == $past(EXT_CAPABLE))
    else $error("capability flag wrong");
  upper_rsv_a: assert property (MSR_REQ.rd && ext && MSR_REQ.index == 32'h0000_0803
    |=> MSR_ACK && MSR_RD_HI == 32'h0000_0000) else $error("upper word not reserved");
  format_gone_a: assert property (any_rq && ext && MSR_REQ.index == 32'h0000_080E
    |=> GP_FAULT) else $error("format register reachable in extended mode");
  cover property (base_wr && MSR_REQ.lo[11:10] == 2'b11);
  cover property (GP_FAULT);
  cover property (MSR_REQ.rd && ext && MSR_REQ.index == 32'h0000_0830);
endmodule

bind ium_top ium_props u_props (.CLK(CLK), .RST_N(RST_N), .MSR_REQ(MSR_REQ),
  .MMIO_REQ(MMIO_REQ), .EXT_CAPABLE(EXT_CAPABLE), .MSR_ACK(MSR_ACK),
  .MSR_RD_HI(MSR_RD_HI), .GP_FAULT(GP_FAULT), .MMIO_ACK(MMIO_ACK),
  .FEATURE_CAP(FEATURE_CAP), .MODE(MODE));

// [tb/ium_core_model.sv]
module ium_core_model
  import ium_pkg::*;
(
  input wire logic clk,
  input wire logic ack,
  input wire logic gp,
  input wire logic miss,
  input wire logic [31:0] rd_lo,
  input wire logic [31:0] rd_hi,
  output ium_msr_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Core side of the register instructions
  // ----------------------------------------------------------------
  initial req = '0;
  // A core retires one instruction per call, so the request stands for exactly one edge.
  task automatic xfer(input logic wr, input logic [31:0] idx, input logic [63:0] val,
                      output logic [2:0] st, output logic [63:0] res);
    @(posedge clk);
    req <= '{rd: !wr, wr: wr, index: idx, lo: val[31:0], hi: val[63:32]};
    @(posedge clk);
    req <= '0;
    #1;
    st = {ack, gp, miss};
    res = {rd_hi, rd_lo};
  endtask
endmodule

// [tb/interrupt_unit_mode_msr_map_test.sv]
module interrupt_unit_mode_msr_map_test;
  import ium_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Stimulus and checks
  // ----------------------------------------------------------------
  localparam logic [2:0] OK = 3'h4;
  localparam logic [2:0] GP = 3'h2;
  localparam logic [31:0] BASE = IUM_BASE_MSR_ADDR;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  ium_msr_req_t msr_req;
  ium_mmio_req_t mmio_req = '0;
  logic [31:0] unit_id = 32'h0000_0A5C;
  logic ext_capable = 1'b1;
  logic is_bsp = 1'b1;
  logic msr_ack, gp_fault, msr_miss, mmio_ack, feature_cap;
  logic [31:0] rd_lo, rd_hi, mmio_data, ver;
  ium_mode_t mode;
  logic [35:0] mmio_base;
  logic [2:0] st;
  logic [63:0] res;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;

  ium_top uut (.CLK(CLK), .RST_N(RST_N), .MSR_REQ(msr_req), .MMIO_REQ(mmio_req),
    .UNIT_ID(unit_id), .EXT_CAPABLE(ext_capable), .IS_BSP(is_bsp), .MSR_ACK(msr_ack),
    .MSR_RD_LO(rd_lo), .MSR_RD_HI(rd_hi), .GP_FAULT(gp_fault), .MSR_MISS(msr_miss),
    .MMIO_ACK(mmio_ack), .MMIO_RD_DATA(mmio_data), .FEATURE_CAP(feature_cap),
    .MODE(mode), .MMIO_BASE(mmio_base));
  ium_core_model core (.clk(CLK), .ack(msr_ack), .gp(gp_fault), .miss(msr_miss),
    .rd_lo(rd_lo), .rd_hi(rd_hi), .req(msr_req));

  always #2.5 CLK = ~CLK;
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk_st(input logic [2:0] exp);
    comparisons++;
    if (st !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: status %b expected %b", $time, st, exp);
    end
  endtask
  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  task automatic msr(input logic wr, input logic [31:0] idx, input logic [63:0] val,
                     input logic [2:0] exp);
    core.xfer(wr, idx, val, st, res);
    chk_st(exp);
  endtask
  task automatic mm_rd(input logic [11:0] ofs);
    @(posedge CLK);
    mmio_req <= '{rd: 1'b1, wr: 1'b0, ofs: ofs, data: 32'h0000_0000};
    @(posedge CLK);
    mmio_req <= '0;
    #1;
  endtask

  initial begin
    ver = {7'h0, ext_capable, IUM_MAX_LVT, 8'h00, IUM_VERSION};
    repeat (5) @(posedge CLK);
    RST_N <= 1'b1;
    chk_val({26'h0, mode, mmio_base}, {26'h0, IUM_LEGACY, 36'h0_FEE0_0000});
    msr(1'b0, BASE, 64'h0, OK);
    chk_val(res, 64'h0000_0000_FEE0_0900);
    mm_rd(IUM_OFS_VER);
    chk_val({31'h0, mmio_ack, mmio_data}, {31'h1, ver});
    msr(1'b0, 32'h0000_0802, 64'h0, GP);
    msr(1'b1, BASE, 64'h0000_0000_FEE0_0400, GP);
    msr(1'b1, BASE, 64'h0000_0000_FEE0_0C00, OK);
    chk_val({62'h0, mode}, {62'h0, IUM_EXTENDED});
    chk_val({63'h0, feature_cap}, {63'h0, ext_capable});
    $display("legacy mode test done");
    mm_rd(IUM_OFS_VER);
    chk_val({31'h0, mmio_ack, mmio_data}, 64'h0);
    msr(1'b0, IUM_XR_BASE | 32'(IUM_OFS_ID >> 4), 64'h0, OK);
    chk_val(res, {32'h0, unit_id});
    msr(1'b0, 32'h0000_0803, 64'h0, OK);
    chk_val(res, {32'h0, ver});
    msr(1'b1, 32'h0000_0830, 64'h1234_5678_0000_0C41, OK);
    msr(1'b0, 32'h0000_0830, 64'h0, OK);
    chk_val(res, 64'h1234_5678_0000_0C41);
    msr(1'b1, 32'h0000_0802, 64'h0, GP);
    msr(1'b1, 32'h0000_083F, 64'h0000_0001_0000_0020, GP);
    msr(1'b1, 32'h0000_083F, 64'h0000_0000_0000_0020, OK);
    msr(1'b0, 32'h0000_080E, 64'h0, GP);
    msr(1'b0, 32'h0000_0BFF, 64'h0, GP);
    msr(1'b0, 32'h0000_0C00, 64'h0, 3'h1);
    $display("extended map test done");
    msr(1'b1, BASE, 64'h0000_0000_FEE0_0800, GP);
    chk_val({62'h0, mode}, {62'h0, IUM_EXTENDED});
    msr(1'b1, BASE, 64'h0, OK);
    chk_val({62'h0, mode}, {62'h0, IUM_DISABLED});
    $display("mode exit test done");
    complete_run();
  end
endmodule
